// [shared/ctp_pkg.sv]
package ctp_pkg;
  // sizes of the channel and signal arrays
  localparam int NCH  = 2;
  localparam int NSIG = 4;

  // one millisecond period tick, derived from the 40 ns clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYC_DFLT = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // byte offsets; channel c sits at c * CH_STRIDE
  localparam logic [7:0] CH_STRIDE  = 8'h40;
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_PGNPER   = 8'h04;
  localparam logic [7:0] A_SIG0     = 8'h08;
  localparam logic [7:0] SIG_STRIDE = 8'h0C;
  localparam logic [7:0] A_STATUS   = 8'h80;

  // field positions
  localparam int CTRL_EN  = 0;
  localparam int CTRL_PRI = 4;
  localparam int CTRL_LEN = 8;
  localparam int CTRL_DA  = 16;
  localparam int PER_LSB  = 16;
  localparam int CFG_SIZE = 0;
  localparam int CFG_BYTE = 4;
  localparam int CFG_BIT  = 8;
  localparam int CFG_SRC  = 12;
  localparam int CFG_NUM  = 16;

  // values after reset: priority 6, length 8, null destination, period 1000 ms
  localparam logic [31:0] CTRL_RST   = 32'h00FE_0860;
  localparam logic [31:0] PGNPER_RST = 32'h03E8_FF00;
  localparam logic [31:0] CFG_RST    = 32'h0000_0000;
  localparam logic [31:0] GAIN_RST   = 32'h0001_0000;
  localparam logic [31:0] OFFS_RST   = 32'h0000_0000;

  // size codes
  localparam logic [2:0] SZ_NONE = 3'h0;
  localparam logic [2:0] SZ_1B   = 3'h1;
  localparam logic [2:0] SZ_2B   = 3'h2;
  localparam logic [2:0] SZ_4B   = 3'h3;
  localparam logic [2:0] SZ_8B   = 3'h4;
  localparam logic [2:0] SZ_16B  = 3'h5;
  localparam logic [2:0] SZ_32B  = 3'h6;

  localparam logic [7:0] PF_PDU2 = 8'hF0;
  localparam logic [7:0] SA_DFLT = 8'h80;  // arbitrary own address
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} ctp_state_type;
endpackage

// [hw/ctp_top.sv]
// What this block does
// [RULE_01] each channel packs up to four separately configured signals into its payload
// [RULE_02] size code 0 unused, 1..6 mean 1, 2, 4 bits, 1, 2, 4 bytes
// [RULE_03] signal's low byte lands at configured byte position 0 to 7
// [RULE_04] bit-sized signals start at configured bit 0 to 7; byte sizes ignore it
// [RULE_05] raw field computed from value using each signal's own gain and offset
// [RULE_06] signal value chosen by data source and instance number
// [RULE_07] PDU1 messages carry configured destination address, reset value 254
// [RULE_08] channels sharing a group are timed by the lowest-indexed one only
// [RULE_09] lowest sharer with zero period silences the whole group
// [RULE_10] enabled channel with nonzero period sends once per period, else never
// [RULE_11] priority field from 3-bit setting (6 at reset), length from setting
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ctp_top #(
  parameter int TICK_CYC = ctp_pkg::TICK_CYC_DFLT   // clock cycles per millisecond
) (
  input  wire logic          CLK,           // system clock
  input  wire logic          RST,           // async reset, active high
  input  wire logic [7:0]    S_AWADDR,      // write address
  input  wire logic          S_AWVALID,     // write address valid
  output logic               S_AWREADY,     // write address ready
  input  wire logic [31:0]   S_WDATA,       // write data
  input  wire logic [3:0]    S_WSTRB,       // byte enables
  input  wire logic          S_WVALID,      // write data valid
  output logic               S_WREADY,      // write data ready
  output logic [1:0]         S_BRESP,       // write response
  output logic               S_BVALID,      // write response valid
  input  wire logic          S_BREADY,      // write response ready
  input  wire logic [7:0]    S_ARADDR,      // read address
  input  wire logic          S_ARVALID,     // read address valid
  output logic               S_ARREADY,     // read address ready
  output logic [31:0]        S_RDATA,       // read data
  output logic [1:0]         S_RRESP,       // read response
  output logic               S_RVALID,      // read data valid
  input  wire logic          S_RREADY,      // read data ready
  input  wire logic [511:0]  SRC_VALUES,    // 16 signed words, {source,instance}
  output logic               TX_VALID,      // frame offered
  input  wire logic          TX_READY,      // frame taken
  output logic [28:0]        TX_ID,         // extended identifier
  output logic [3:0]         TX_LEN,        // payload length in bytes
  output logic [63:0]        TX_DATA        // payload, byte 0 in bits 7:0
);
  localparam int NCH = ctp_pkg::NCH;
  localparam int NSIG = ctp_pkg::NSIG;

  logic [31:0] ctrl_q [NCH];
  logic [31:0] pgnper_q [NCH];
  logic [31:0] cfg_q [NCH][NSIG];
  logic [31:0] gain_q [NCH][NSIG];
  logic [31:0] offs_q [NCH][NSIG];
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [15:0] tick_q;
  logic [15:0] cnt_q [NCH];
  logic [NCH-1:0] pend_q, pend_d, fire_w, owner_w, set_w, clr_w;
  logic        cur_q;
  logic        ld_ch;
  logic        load_w;
  logic [63:0] pack_w;
  logic signed [31:0] raw_w [NSIG];
  ctp_pkg::ctp_state_type state_q;

  // decode: {ok, kind, ch, sig}; kind 0 ctrl 1 pgnper 2 cfg 3 gain 4 offset 5 status
  function automatic logic [6:0] dec(input logic [7:0] a);
    logic [5:0] o;
    logic [5:0] r;
    o = a[5:0];
    r = o - 6'(ctp_pkg::A_SIG0);
    dec = 7'h00;
    if (a == ctp_pkg::A_STATUS) begin
      dec = {1'b1, 3'h5, 3'h0};
    end else if (a[7] || a[1:0] != 2'h0) begin
      dec = 7'h00;
    end else if (o == 6'(ctp_pkg::A_CTRL)) begin
      dec = {1'b1, 3'h0, a[6], 2'h0};
    end else if (o == 6'(ctp_pkg::A_PGNPER)) begin
      dec = {1'b1, 3'h1, a[6], 2'h0};
    end else if (o >= 6'(ctp_pkg::A_SIG0) && r < 6'(NSIG * ctp_pkg::SIG_STRIDE)) begin
      dec = {1'b1, 3'(3'h2 + (r % 6'(ctp_pkg::SIG_STRIDE)) / 6'h4), a[6],
             2'(r / 6'(ctp_pkg::SIG_STRIDE))};
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : o[b*8 +: 8];
  endfunction

  logic [6:0] wdec;
  logic       wdo;
  assign wdec = dec(awaddr_q);
  assign wdo  = !S_AWREADY && !S_WREADY && !S_BVALID;

  // write channel: address and data taken in either order, answered once both are in
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AWREADY <= 1'b1;
      S_WREADY  <= 1'b1;
      S_BVALID  <= 1'b0;
      S_BRESP   <= ctp_pkg::RESP_OK;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (S_AWVALID && S_AWREADY) begin
        S_AWREADY <= 1'b0;
        awaddr_q  <= S_AWADDR;
      end
      if (S_WVALID && S_WREADY) begin
        S_WREADY <= 1'b0;
        wdata_q  <= S_WDATA;
        wstrb_q  <= S_WSTRB;
      end
      if (wdo) begin
        S_BVALID <= 1'b1;
        S_BRESP  <= wdec[6] ? ctp_pkg::RESP_OK : ctp_pkg::RESP_ERR;
      end
      if (S_BVALID && S_BREADY) begin
        S_BVALID  <= 1'b0;
        S_AWREADY <= 1'b1;
        S_WREADY  <= 1'b1;
      end
    end
  end

  // configuration store; status is read only so a write there is accepted and dropped
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_q[c]   <= ctp_pkg::CTRL_RST;    // RULE_07 RULE_11
        pgnper_q[c] <= ctp_pkg::PGNPER_RST;
        for (int k = 0; k < NSIG; k++) begin
          cfg_q[c][k]  <= ctp_pkg::CFG_RST;
          gain_q[c][k] <= ctp_pkg::GAIN_RST;
          offs_q[c][k] <= ctp_pkg::OFFS_RST;
        end
      end
    end else if (wdo && wdec[6]) begin
      case (wdec[5:3])
        3'h0: ctrl_q[wdec[2]] <= merge(ctrl_q[wdec[2]], wdata_q, wstrb_q);
        3'h1: pgnper_q[wdec[2]] <= merge(pgnper_q[wdec[2]], wdata_q, wstrb_q);
        3'h2: cfg_q[wdec[2]][wdec[1:0]] <= merge(cfg_q[wdec[2]][wdec[1:0]], wdata_q, wstrb_q);
        3'h3: gain_q[wdec[2]][wdec[1:0]] <= merge(gain_q[wdec[2]][wdec[1:0]], wdata_q, wstrb_q);
        3'h4: offs_q[wdec[2]][wdec[1:0]] <= merge(offs_q[wdec[2]][wdec[1:0]], wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // read channel: one cycle from address to data
  logic [6:0] rdec;
  assign rdec = dec(S_ARADDR);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_ARREADY <= 1'b1;
      S_RVALID  <= 1'b0;
      S_RDATA   <= 32'h0000_0000;
      S_RRESP   <= ctp_pkg::RESP_OK;
    end else if (S_ARVALID && S_ARREADY) begin
      S_ARREADY <= 1'b0;
      S_RVALID  <= 1'b1;
      S_RRESP   <= rdec[6] ? ctp_pkg::RESP_OK : ctp_pkg::RESP_ERR;
      case (rdec[5:3])
        3'h0: S_RDATA <= rdec[6] ? ctrl_q[rdec[2]] : 32'h0000_0000;
        3'h1: S_RDATA <= pgnper_q[rdec[2]];
        3'h2: S_RDATA <= cfg_q[rdec[2]][rdec[1:0]];
        3'h3: S_RDATA <= gain_q[rdec[2]][rdec[1:0]];
        3'h4: S_RDATA <= offs_q[rdec[2]][rdec[1:0]];
        default: S_RDATA <= {28'h0000000, 1'(state_q == ctp_pkg::ST_SEND), cur_q, pend_q};
      endcase
    end else if (S_RVALID && S_RREADY) begin
      S_RVALID  <= 1'b0;
      S_ARREADY <= 1'b1;
    end
  end

  // group ownership: lowest enabled channel with a given group number times it
  always_comb begin
    owner_w = '0;
    for (int i = 0; i < NCH; i++) begin
      owner_w[i] = ctrl_q[i][ctp_pkg::CTRL_EN];
      for (int j = 0; j < i; j++)
        if (ctrl_q[j][ctp_pkg::CTRL_EN] && pgnper_q[j][15:0] == pgnper_q[i][15:0])
          owner_w[i] = 1'b0;                                            // RULE_08
    end
  end

  // millisecond prescaler shared by all channel timers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) tick_q <= 16'h0000;
    else if (tick_q == 16'(TICK_CYC - 1)) tick_q <= 16'h0000;
    else tick_q <= tick_q + 16'h0001;
  end

  // owner timers; only an owner with nonzero period ever fires
  always_comb begin
    for (int i = 0; i < NCH; i++)
      fire_w[i] = owner_w[i] && pgnper_q[i][31:16] != 16'h0000 &&     // RULE_09 RULE_10
                  tick_q == 16'(TICK_CYC - 1) && cnt_q[i] + 16'h0001 >= pgnper_q[i][31:16];
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NCH; i++) cnt_q[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < NCH; i++)
        if (!owner_w[i] || fire_w[i]) cnt_q[i] <= 16'h0000;
        else if (tick_q == 16'(TICK_CYC - 1)) cnt_q[i] <= cnt_q[i] + 16'h0001;
    end
  end

  // a firing owner marks every enabled sharer; a new mark beats a clear
  always_comb begin
    set_w = '0;
    for (int j = 0; j < NCH; j++)
      for (int i = 0; i < NCH; i++)
        if (fire_w[i] && ctrl_q[j][ctp_pkg::CTRL_EN] &&
            pgnper_q[j][15:0] == pgnper_q[i][15:0]) set_w[j] = 1'b1;  // RULE_08
    ld_ch  = pend_q[0] ? 1'b0 : 1'b1;     // lowest pending goes first
    load_w = state_q == ctp_pkg::ST_IDLE && pend_q != '0;
    clr_w  = '0;
    if (load_w) clr_w[ld_ch] = 1'b1;
    pend_d = (pend_q & ~clr_w) | set_w;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) pend_q <= '0;
    else pend_q <= pend_d;
  end

  // scaling: raw = (value - offset) * gain, gain signed 16.16
  always_comb begin
    logic signed [31:0] v;
    logic signed [63:0] p;
    v = 32'sh0;
    p = 64'sh0;
    for (int k = 0; k < NSIG; k++) begin
      v = SRC_VALUES[{cfg_q[ld_ch][k][ctp_pkg::CFG_SRC +: 2],
                      cfg_q[ld_ch][k][ctp_pkg::CFG_NUM +: 2]} * 32 +: 32];  // RULE_06
      p = (v - $signed(offs_q[ld_ch][k])) * $signed(gain_q[ld_ch][k]);     // RULE_05
      raw_w[k] = p[47:16];
    end
  end

  // packing: later signals overwrite earlier ones where fields overlap
  always_comb begin
    logic [2:0]  sz;
    logic [63:0] m;
    logic [6:0]  pos;
    pack_w = 64'h0;
    sz = 3'h0;
    m = 64'h0;
    pos = 7'h0;
    for (int k = 0; k < NSIG; k++) begin                                  // RULE_01
      sz = cfg_q[ld_ch][k][ctp_pkg::CFG_SIZE +: 3];
      case (sz)                                                           // RULE_02
        ctp_pkg::SZ_1B:  m = 64'h1;
        ctp_pkg::SZ_2B:  m = 64'h3;
        ctp_pkg::SZ_4B:  m = 64'hF;
        ctp_pkg::SZ_8B:  m = 64'hFF;
        ctp_pkg::SZ_16B: m = 64'hFFFF;
        ctp_pkg::SZ_32B: m = 64'hFFFF_FFFF;
        default:         m = 64'h0;
      endcase
      pos = {1'b0, cfg_q[ld_ch][k][ctp_pkg::CFG_BYTE +: 3], 3'h0};           // RULE_03
      if (sz != ctp_pkg::SZ_NONE && sz < ctp_pkg::SZ_8B)
        pos = pos + {4'h0, cfg_q[ld_ch][k][ctp_pkg::CFG_BIT +: 3]};          // RULE_04
      pack_w = (pack_w & ~(m << pos)) | (({32'h0, raw_w[k]} & m) << pos);
    end
  end

  // frame sender: one frame at a time, held until the link takes it
  logic [7:0] pf;
  assign pf = pgnper_q[ld_ch][15:8];
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q  <= ctp_pkg::ST_IDLE;
      cur_q    <= 1'b0;
      TX_VALID <= 1'b0;
      TX_ID    <= 29'h0000_0000;
      TX_LEN   <= 4'h0;
      TX_DATA  <= 64'h0;
    end else begin
      case (state_q)
        ctp_pkg::ST_IDLE: if (load_w) begin
          state_q  <= ctp_pkg::ST_SEND;
          cur_q    <= ld_ch;
          TX_VALID <= 1'b1;
          TX_DATA  <= pack_w;
          TX_LEN   <= ctrl_q[ld_ch][ctp_pkg::CTRL_LEN +: 4];                 // RULE_11
          TX_ID    <= {ctrl_q[ld_ch][ctp_pkg::CTRL_PRI +: 3], 2'h0, pf,      // RULE_11
                       pf < ctp_pkg::PF_PDU2 ? ctrl_q[ld_ch][ctp_pkg::CTRL_DA +: 8]
                                             : pgnper_q[ld_ch][7:0],          // RULE_07
                       ctp_pkg::SA_DFLT};
        end
        ctp_pkg::ST_SEND: if (TX_READY) begin
          state_q  <= ctp_pkg::ST_IDLE;
          TX_VALID <= 1'b0;
        end
        default: state_q <= ctp_pkg::ST_IDLE;
      endcase
    end
  end

  a_prio_field: assert property (@(posedge CLK) disable iff (RST)  // RULE_11
    load_w |=> TX_ID[28:26] == $past(ctrl_q[ld_ch][6:4]))
    else $error("priority field wrong");
  a_len_field: assert property (@(posedge CLK) disable iff (RST)  // RULE_11
    load_w |=> TX_LEN == $past(ctrl_q[ld_ch][11:8]))
    else $error("length field wrong");
  a_dest_pdu1: assert property (@(posedge CLK) disable iff (RST)  // RULE_07
    load_w && pf < 8'hF0 |=> TX_ID[15:8] == $past(ctrl_q[ld_ch][23:16]))
    else $error("destination address wrong");
  a_owner_fires: assert property (@(posedge CLK) disable iff (RST)  // RULE_08
    fire_w[1] |-> !(ctrl_q[0][0] && pgnper_q[0][15:0] == pgnper_q[1][15:0]))
    else $error("higher sharer fired");
  a_zero_silent: assert property (@(posedge CLK) disable iff (RST)  // RULE_09
    pgnper_q[0][31:16] == 16'h0000 && ctrl_q[0][0] && !pend_q[0] |=> !pend_q[0])
    else $error("zero period sent");
  a_off_quiet: assert property (@(posedge CLK) disable iff (RST)  // RULE_10
    $rose(pend_q[1]) |-> $past(ctrl_q[1][0]))
    else $error("disabled channel queued");
  a_byte_place: assert property (@(posedge CLK) disable iff (RST)  // RULE_03
    load_w && cfg_q[ld_ch][3][2:0] == 3'h4 |=>
    TX_DATA[$past(cfg_q[ld_ch][3][6:4]) * 8 +: 8] == $past(raw_w[3][7:0]))
    else $error("byte signal misplaced");
  a_bit_place: assert property (@(posedge CLK) disable iff (RST)  // RULE_04
    load_w && cfg_q[ld_ch][3][2:0] == 3'h1 |=>
    TX_DATA[{$past(cfg_q[ld_ch][3][6:4]), $past(cfg_q[ld_ch][3][10:8])}] == $past(raw_w[3][0]))
    else $error("bit signal misplaced");
  a_frame_hold: assert property (@(posedge CLK) disable iff (RST)  // RULE_01
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_ID))
    else $error("frame changed before taken");
endmodule // ctp_top
`default_nettype wire

// [tb/ctp_node_model.sv]
`timescale 1ns/1ps
`default_nettype none
// far-side node: takes each offered frame after a stall, prompt or slow
module ctp_node_model (
  input  wire logic        clk,       // system clock
  input  wire logic        rst,       // async reset, active high
  input  wire logic [7:0]  stall,     // cycles held off before taking
  input  wire logic        tx_valid,  // frame offered
  output logic             tx_ready,  // frame taken
  input  wire logic [28:0] tx_id,     // identifier
  input  wire logic [3:0]  tx_len,    // length
  input  wire logic [63:0] tx_data,   // payload
  output int               n_frames,  // frames taken so far
  output logic [28:0]      last_id,   // last identifier
  output logic [3:0]       last_len,  // last length
  output logic [63:0]      last_data  // last payload
);
  logic [7:0] wait_q;

  // ready only after the stall; dropped at once so no frame is taken twice
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ready  <= 1'b0;
      wait_q    <= 8'h00;
      n_frames  <= 0;
      last_id   <= 29'h0;
      last_len  <= 4'h0;
      last_data <= 64'h0;
    end else if (tx_valid && tx_ready) begin
      tx_ready  <= 1'b0;
      wait_q    <= 8'h00;
      n_frames  <= n_frames + 1;
      last_id   <= tx_id;
      last_len  <= tx_len;
      last_data <= tx_data;
    end else if (tx_valid) begin
      if (wait_q >= stall) tx_ready <= 1'b1;
      else wait_q <= wait_q + 8'h01;
    end
  end
endmodule // ctp_node_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TICK = 10;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, stall;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [511:0] src;
  wire logic   awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [28:0] tx_id, l_id;
  wire logic [3:0]  tx_len, l_len;
  wire logic [63:0] tx_data, l_data;
  int          n_fr, n_mismatch, samples_checked;

  ctp_top #(.TICK_CYC(TICK)) u_dut (.CLK(clk), .RST(rst), .S_AWADDR(awaddr),
    .S_AWVALID(awvalid), .S_AWREADY(awready), .S_WDATA(wdata), .S_WSTRB(wstrb),
    .S_WVALID(wvalid), .S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid),
    .S_BREADY(bready), .S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready),
    .S_RDATA(rdata), .S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rready),
    .SRC_VALUES(src), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_ID(tx_id),
    .TX_LEN(tx_len), .TX_DATA(tx_data));

  ctp_node_model u_node (.clk(clk), .rst(rst), .stall(stall), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_id(tx_id), .tx_len(tx_len), .tx_data(tx_data),
    .n_frames(n_fr), .last_id(l_id), .last_len(l_len), .last_data(l_data));

  // 25 MHz system clock
  always #20 clk = ~clk;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check(64'(bresp), 64'(ctp_pkg::RESP_OK));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // waits for k more frames; cyc is the time it took
  task automatic wait_fr(input int k, output int cyc);
    int n0;
    n0 = n_fr;
    cyc = 0;
    while (n_fr < n0 + k) begin
      @(posedge clk);
      cyc++;
    end
  endtask

  task automatic count_fr(input int n, output int d);
    int n0;
    n0 = n_fr;
    repeat (n) @(posedge clk);
    d = n_fr - n0;
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h40, d, r);
    check(d[23:16], 8'hFE);
    check(d[6:4], 3'h6);
    rd(8'h04, d, r);
    check(d[31:16], 16'd1000);
    rd(8'h0C, d, r);
    check(d, ctp_pkg::GAIN_RST);
    rd(8'h38, d, r);
    check({r, d}, {ctp_pkg::RESP_ERR, 32'h0});
    rd(8'h80, d, r);
    check({r, d}, {ctp_pkg::RESP_OK, 32'h0});
    $display("test reset done");
  endtask

  // every size code on signal 3 with an all-ones source, bit 3 of byte 1
  task automatic t_sizes;
    logic [63:0] m;
    int          c, sh;
    wr(8'h00, 32'h00FE_0861);
    wr(8'h04, 32'h0001_FF10);
    for (int i = 0; i < 7; i++) begin
      wr(8'h2C, 32'h0003_3310 | 32'(i));
      m = (i == 0) ? 64'h0 : (64'h1 << (i < 4 ? (1 << (i - 1)) : (8 << (i - 4)))) - 64'h1;
      sh = (i > 0 && i < 4) ? 11 : 8;
      wait_fr(2, c);
      check(l_data, m << sh);
    end
    check(l_id, {3'h6, 2'b00, 8'hFF, 8'h10, ctp_pkg::SA_DFLT});
    $display("test sizes done");
  endtask

  // four signals, own sources, gains and offsets, PDU1 destination
  task automatic t_pack;
    int c;
    wr(8'h00, 32'h0035_0831);
    wr(8'h04, 32'h0001_EF00);
    wr(8'h08, 32'h0001_1004);
    wr(8'h14, 32'h0002_2025);
    wr(8'h18, 32'h0002_0000);
    wr(8'h1C, 32'h0000_0034);
    wr(8'h20, 32'h0003_0612);
    wr(8'h2C, 32'h0003_3046);
    wr(8'h34, 32'hFFFF_FFFD);
    wait_fr(2, c);
    check(l_data, 64'h0000_0002_2400_C0A5);
    check(l_id, {3'h3, 2'b00, 8'hEF, 8'h35, ctp_pkg::SA_DFLT});
    $display("test pack done");
  endtask

  // slow taker; spacing is the period, and a disabled channel stays quiet
  task automatic t_period;
    int c;
    stall <= 8'h05;
    wr(8'h00, 32'h00FE_0561);
    wr(8'h04, 32'h0002_FF10);
    wait_fr(2, c);
    wait_fr(1, c);
    check(64'(c), 64'(2 * TICK));
    check(l_len, 4'h5);
    wr(8'h00, 32'h00FE_0560);
    repeat (30) @(posedge clk);
    count_fr(100, c);
    check(64'(c), 64'h0);
    stall <= 8'h00;
    $display("test period done");
  endtask

  // both channels on one group; channel 0 period decides alone
  task automatic t_share;
    int c;
    wr(8'h04, 32'h0000_FF20);
    wr(8'h00, 32'h00FE_0861);
    wr(8'h44, 32'h0001_FF20);
    wr(8'h40, 32'h00FE_0861);
    repeat (30) @(posedge clk);
    count_fr(100, c);
    check(64'(c), 64'h0);
    wr(8'h04, 32'h0003_FF20);
    repeat (60) @(posedge clk);
    count_fr(300, c);
    check(64'(c >= 18 && c <= 22), 64'h1);
    $display("test share done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    clk = 1'b0; rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'hF; stall = 8'h00; src = '0;
    src[5*32 +: 32] = 32'h0000_00A5;
    src[10*32 +: 32] = 32'h0000_1234;
    src[3*32 +: 32] = 32'h0000_0007;
    src[15*32 +: 32] = 32'hFFFF_FFFF;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_sizes;
    t_pack;
    t_period;
    t_share;
    complete_run;
  end

  // watchdog well beyond the roughly one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
